/* File: common/pcr_pkg.sv */
// Purpose: Shared constants of the PHY configuration register bank
// Assumes: 20 MHz hclk, AHB-Lite word access
// Notes:   Register index times four gives the byte address
package pcr_pkg;
  // ==========================================================
  // Register indices
  localparam logic [9:0] IDX_TEST_MIRROR = 10'h031;
  localparam logic [9:0] IDX_RGMII_CTL   = 10'h032;
  localparam logic [9:0] IDX_RGMII_CTL2  = 10'h033;
  localparam logic [9:0] IDX_FE_CFG      = 10'h043;

  // ==========================================================
  // Field positions
  localparam int TM_SEL_BIT     = 7;
  localparam int TM_RSV_RW_BIT  = 8;
  localparam int TM_MIRROR_BIT  = 0;
  localparam int RG_EN_BIT      = 7;
  localparam int RG_RXTH_LSB    = 5;
  localparam int RG_TXTH_LSB    = 3;
  localparam int RG_TXDLY_BIT   = 1;
  localparam int RG_RXDLY_BIT   = 0;
  localparam int RG2_SKIP_BIT   = 4;
  localparam int FE_WDOFF_BIT   = 11;
  localparam int FE_RECOV_LSB   = 7;
  localparam int FE_FORCE_BIT   = 6;
  localparam int FE_MLT3_BIT    = 5;
  localparam int FE_IPG_BIT     = 4;
  localparam int FE_DECSKIP_BIT = 3;
  localparam int FE_SCROFF_BIT  = 2;
  localparam int FE_ODD_BIT     = 1;
  localparam int FE_EARLY_BIT   = 0;

  // ==========================================================
  // Reset values, read-only constants and strap mode codes
  localparam logic [15:0] TM_RO_CONST  = 16'h1010;
  localparam logic [1:0]  FIFO_TH_RST  = 2'h2;
  localparam logic        CLK_DLY_RST  = 1'b1;
  localparam logic [3:0]  RECOV_RST    = 4'hF;
  localparam logic        MLT3_RST     = 1'b1;
  localparam logic [1:0]  STRAP_MODE1  = 2'h1;
  localparam logic [1:0]  STRAP_MODE2  = 2'h2;

  // ==========================================================
  // Timing
  localparam int CLK_KHZ           = 20000;
  localparam int UNSCR_TIMEOUT_US  = 1500;
  localparam int UNSCR_TIMEOUT_CYC = UNSCR_TIMEOUT_US * CLK_KHZ / 1000;
  localparam int MS_US             = 1000;
  localparam int MS_CYC            = MS_US * CLK_KHZ / 1000;

  // AHB transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage : pcr_pkg

/* File: verilog/pcr_regs.sv */
// Purpose: Test, mirror, RGMII and 100BASE-TX configuration bank on AHB-Lite
// Assumes: Strap and datapath inputs synchronous to hclk
// Notes:   Writes take no wait state, reads take one
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps

// Behaviour
// RULE_01: Strap mode1 or mode2 sets internal test select, entering test mode.
// RULE_02: Software writing zero to test select overrides strap, returns normal.
// RULE_03: Mirror enable bit turns on port mirroring; reset value from strap.
// RULE_04: RGMII enable bit activates interface; reset one small package, else strap.
// RULE_05: Two-bit receive FIFO midlevel threshold, default binary 10.
// RULE_06: Two-bit transmit FIFO midlevel threshold, default binary 10.
// RULE_07: Transmit clock skew bit, default one, shifts clock against data.
// RULE_08: Receive clock skew bit, default one, shifts clock against data.
// RULE_09: Interface control upper byte and bit 2 ignore writes, read zero.
// RULE_10: Async FIFO skip bit bypasses RGMII async FIFO; default keeps it.
// RULE_11: Watchdog clear stops receiving any packet longer than 1.5 ms.
// RULE_12: Four-bit millisecond field, default all ones, sets unlock recovery time.
// RULE_13: Fast-link good override forces 100 Mb/s link to report good.
// RULE_14: Improved ternary detect bit enables enhanced MLT-3 detector, default one.
// RULE_15: Improved gap detect enables enhanced interpacket gap detection, default zero.
// RULE_16: Block decoder skip removes 4B/5B decoder from receive path.
// RULE_17: Scrambler-off bit disables the 100 Mb/s scrambler.
// RULE_18: Odd half-byte check set detects odd count of received nibbles.
// RULE_19: Early receive-valid bit enables fast receive-valid timing.
// RULE_20: Reserved read-only fields read their defaults; writes have no effect.
module pcr_regs #(
  parameter int          AW          = 12,
  parameter bit          SMALL_PKG   = 1'b1,
  parameter int unsigned TIMEOUT_CYC = pcr_pkg::UNSCR_TIMEOUT_CYC,
  parameter int unsigned MS_CYC      = pcr_pkg::MS_CYC
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [AW-1:0] haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  input  wire logic [1:0]    rx_ctrl_strap,
  input  wire logic          mirror_strap,
  input  wire logic          rgmii_en_strap,
  input  wire logic          rx_packet_active,
  input  wire logic          unscramble_unlock,
  input  wire logic          link_qualified,
  input  wire logic          rx_nibble_valid,
  input  wire logic          rx_frame_end,
  output logic               internal_test_mode,
  output logic               port_mirror,
  output logic               rgmii_enable,
  output logic [1:0]         rx_fifo_midlevel,
  output logic [1:0]         tx_fifo_midlevel,
  output logic               tx_clk_skew,
  output logic               rx_clk_skew,
  output logic               async_fifo_skip,
  output logic               rx_packet_abort,
  output logic               unscramble_recovering,
  output logic               link_good_100,
  output logic               improved_ternary_detect,
  output logic               improved_gap_detect,
  output logic               rx_block_decoder_skip,
  output logic               scrambler_off,
  output logic               odd_nibble_seen,
  output logic               early_receive_valid
);
  // ==========================================================
  // Elaboration checks
  if (AW < 12) begin : g_chk_aw
    $error("address width too small for the register map");
  end
  if (TIMEOUT_CYC < 1 || MS_CYC < 1) begin : g_chk_cyc
    $error("timing counts must be at least one");
  end

  function automatic logic is_reg(input logic [AW-1:0] a, input logic [9:0] idx);
    return a[11:2] == idx;
  endfunction : is_reg

  // ==========================================================
  // AHB-Lite slave
  logic          wr_pend_q;
  logic          rd_pend_q;
  logic [AW-1:0] addr_q;
  logic          addr_take;
  logic          wr_now;

  assign addr_take = hsel && hready && htrans[1];
  assign wr_now    = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= '0;
    end else if (hready) begin
      wr_pend_q <= addr_take && hwrite;
      rd_pend_q <= addr_take && !hwrite;
      if (addr_take) begin
        addr_q <= haddr;
      end
    end
  end

  // ==========================================================
  // Stored fields
  logic       strap_done_q;
  logic       tm_sel_q;
  logic       tm_rsv_q;
  logic       mirror_q;
  logic       rg_en_q;
  logic [1:0] rx_th_q;
  logic [1:0] tx_th_q;
  logic       tx_dly_q;
  logic       rx_dly_q;
  logic       skip_q;
  logic [11:0] fe_q;

  // RULE_01 strap test entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_q <= 1'b0;
      tm_sel_q     <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      tm_sel_q     <= (rx_ctrl_strap == pcr_pkg::STRAP_MODE1) || (rx_ctrl_strap == pcr_pkg::STRAP_MODE2);
    // RULE_02 software override
    end else if (wr_now && is_reg(addr_q, pcr_pkg::IDX_TEST_MIRROR)) begin
      tm_sel_q <= hwdata[pcr_pkg::TM_SEL_BIT];
    end
  end

  // RULE_03 mirror strap default
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mirror_q <= 1'b0;
      tm_rsv_q <= 1'b0;
    end else if (!strap_done_q) begin
      mirror_q <= mirror_strap;
    end else if (wr_now && is_reg(addr_q, pcr_pkg::IDX_TEST_MIRROR)) begin
      mirror_q <= hwdata[pcr_pkg::TM_MIRROR_BIT];
      tm_rsv_q <= hwdata[pcr_pkg::TM_RSV_RW_BIT];
    end
  end

  // RULE_04 RGMII enable default
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rg_en_q  <= 1'b1;
      rx_th_q  <= pcr_pkg::FIFO_TH_RST;
      tx_th_q  <= pcr_pkg::FIFO_TH_RST;
      tx_dly_q <= pcr_pkg::CLK_DLY_RST;
      rx_dly_q <= pcr_pkg::CLK_DLY_RST;
    end else if (!strap_done_q) begin
      rg_en_q <= SMALL_PKG ? 1'b1 : rgmii_en_strap;
    // RULE_09 reserved bits not stored
    end else if (wr_now && is_reg(addr_q, pcr_pkg::IDX_RGMII_CTL)) begin
      rg_en_q  <= hwdata[pcr_pkg::RG_EN_BIT];
      // RULE_05 receive threshold
      rx_th_q  <= hwdata[pcr_pkg::RG_RXTH_LSB +: 2];
      // RULE_06 transmit threshold
      tx_th_q  <= hwdata[pcr_pkg::RG_TXTH_LSB +: 2];
      // RULE_07 transmit skew
      tx_dly_q <= hwdata[pcr_pkg::RG_TXDLY_BIT];
      // RULE_08 receive skew
      rx_dly_q <= hwdata[pcr_pkg::RG_RXDLY_BIT];
    end
  end

  // RULE_10 async FIFO skip
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip_q <= 1'b0;
    end else if (wr_now && is_reg(addr_q, pcr_pkg::IDX_RGMII_CTL2)) begin
      skip_q <= hwdata[pcr_pkg::RG2_SKIP_BIT];
    end
  end

  // 100BASE-TX config, bits 11:0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fe_q <= 12'h0;
      fe_q[pcr_pkg::FE_RECOV_LSB +: 4] <= pcr_pkg::RECOV_RST;
      fe_q[pcr_pkg::FE_MLT3_BIT]       <= pcr_pkg::MLT3_RST;
    end else if (wr_now && is_reg(addr_q, pcr_pkg::IDX_FE_CFG)) begin
      fe_q <= hwdata[11:0];
    end
  end

  // ==========================================================
  // Read path, one wait state
  logic [15:0] rd_mux;

  // RULE_20 reserved read defaults
  always_comb begin
    rd_mux = 16'h0;
    if (is_reg(addr_q, pcr_pkg::IDX_TEST_MIRROR)) begin
      rd_mux = pcr_pkg::TM_RO_CONST;
      rd_mux[pcr_pkg::TM_RSV_RW_BIT] = tm_rsv_q;
      rd_mux[pcr_pkg::TM_SEL_BIT]    = tm_sel_q;
      rd_mux[pcr_pkg::TM_MIRROR_BIT] = mirror_q;
    end else if (is_reg(addr_q, pcr_pkg::IDX_RGMII_CTL)) begin
      rd_mux[pcr_pkg::RG_EN_BIT]          = rg_en_q;
      rd_mux[pcr_pkg::RG_RXTH_LSB +: 2]   = rx_th_q;
      rd_mux[pcr_pkg::RG_TXTH_LSB +: 2]   = tx_th_q;
      rd_mux[pcr_pkg::RG_TXDLY_BIT]       = tx_dly_q;
      rd_mux[pcr_pkg::RG_RXDLY_BIT]       = rx_dly_q;
    end else if (is_reg(addr_q, pcr_pkg::IDX_RGMII_CTL2)) begin
      rd_mux[pcr_pkg::RG2_SKIP_BIT] = skip_q;
    end else if (is_reg(addr_q, pcr_pkg::IDX_FE_CFG)) begin
      rd_mux[11:0] = fe_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hready && addr_take && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_q && !hreadyout) begin
        hreadyout <= 1'b1;
        hrdata    <= {16'h0000, rd_mux};
      end
    end
  end

  // ==========================================================
  // Millisecond tick and unlock recovery
  logic [$clog2(MS_CYC+1)-1:0] ms_cnt_q;
  logic                        ms_tick;
  logic [3:0]                  recov_q;

  assign ms_tick = ms_cnt_q == ($clog2(MS_CYC+1))'(MS_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_q <= '0;
    end else if (unscramble_unlock || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 1'b1;
    end
  end

  // RULE_12 recovery in ms
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      recov_q <= 4'h0;
    end else if (unscramble_unlock) begin
      recov_q <= fe_q[pcr_pkg::FE_RECOV_LSB +: 4];
    end else if (ms_tick && recov_q != 4'h0) begin
      recov_q <= recov_q - 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unscramble_recovering <= 1'b0;
    end else begin
      unscramble_recovering <= unscramble_unlock ? (fe_q[pcr_pkg::FE_RECOV_LSB +: 4] != 4'h0) :
                               (recov_q > 4'h1) || (recov_q == 4'h1 && !ms_tick);
    end
  end

  // ==========================================================
  // Packet length watchdog
  logic [$clog2(TIMEOUT_CYC+1)-1:0] pkt_cnt_q;
  logic                             pkt_over;

  assign pkt_over = pkt_cnt_q == ($clog2(TIMEOUT_CYC+1))'(TIMEOUT_CYC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pkt_cnt_q <= '0;
    end else if (!rx_packet_active) begin
      pkt_cnt_q <= '0;
    end else if (!pkt_over) begin
      pkt_cnt_q <= pkt_cnt_q + 1'b1;
    end
  end

  // RULE_11 long packet abort
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_packet_abort <= 1'b0;
    end else begin
      rx_packet_abort <= rx_packet_active && pkt_over && !fe_q[pcr_pkg::FE_WDOFF_BIT];
    end
  end

  // ==========================================================
  // Odd nibble check
  logic nib_odd_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nib_odd_q <= 1'b0;
    end else if (rx_frame_end) begin
      nib_odd_q <= 1'b0;
    end else if (rx_nibble_valid) begin
      nib_odd_q <= !nib_odd_q;
    end
  end

  // RULE_18 odd count pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      odd_nibble_seen <= 1'b0;
    end else begin
      odd_nibble_seen <= rx_frame_end && fe_q[pcr_pkg::FE_ODD_BIT] && (nib_odd_q ^ rx_nibble_valid);
    end
  end

  // ==========================================================
  // Control outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_test_mode      <= 1'b0;
      port_mirror             <= 1'b0;
      rgmii_enable            <= 1'b0;
      rx_fifo_midlevel        <= 2'h0;
      tx_fifo_midlevel        <= 2'h0;
      tx_clk_skew             <= 1'b0;
      rx_clk_skew             <= 1'b0;
      async_fifo_skip         <= 1'b0;
      link_good_100           <= 1'b0;
      improved_ternary_detect <= 1'b0;
      improved_gap_detect     <= 1'b0;
      rx_block_decoder_skip   <= 1'b0;
      scrambler_off           <= 1'b0;
      early_receive_valid     <= 1'b0;
    end else begin
      internal_test_mode      <= tm_sel_q;
      port_mirror             <= mirror_q;
      rgmii_enable            <= rg_en_q;
      rx_fifo_midlevel        <= rx_th_q;
      tx_fifo_midlevel        <= tx_th_q;
      tx_clk_skew             <= tx_dly_q;
      rx_clk_skew             <= rx_dly_q;
      async_fifo_skip         <= skip_q;
      // RULE_13 forced link good
      link_good_100           <= link_qualified || fe_q[pcr_pkg::FE_FORCE_BIT];
      // RULE_14 ternary detector enable
      improved_ternary_detect <= fe_q[pcr_pkg::FE_MLT3_BIT];
      // RULE_15 gap detector enable
      improved_gap_detect     <= fe_q[pcr_pkg::FE_IPG_BIT];
      // RULE_16 decoder bypass
      rx_block_decoder_skip   <= fe_q[pcr_pkg::FE_DECSKIP_BIT];
      // RULE_17 scrambler disable
      scrambler_off           <= fe_q[pcr_pkg::FE_SCROFF_BIT];
      // RULE_19 early receive valid
      early_receive_valid     <= fe_q[pcr_pkg::FE_EARLY_BIT];
    end
  end

  // ==========================================================
  // Assertions
  sequence s_strap_test;
    hresetn && !strap_done_q &&
      ((rx_ctrl_strap == pcr_pkg::STRAP_MODE1) || (rx_ctrl_strap == pcr_pkg::STRAP_MODE2));
  endsequence

  property p_strap_test;
    @(posedge hclk) disable iff (!hresetn) s_strap_test |=> tm_sel_q ##1 internal_test_mode;
  endproperty
  a_strap_test: assert property (p_strap_test) else $error("strap test mode not entered"); // RULE_01

  property p_sw_clear;
    @(posedge hclk) disable iff (!hresetn)
      strap_done_q && wr_now && is_reg(addr_q, pcr_pkg::IDX_TEST_MIRROR) && !hwdata[pcr_pkg::TM_SEL_BIT]
      |=> ##1 !internal_test_mode;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("test mode not cleared by write"); // RULE_02

  property p_mirror;
    @(posedge hclk) disable iff (!hresetn) strap_done_q |=> port_mirror == $past(mirror_q);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror output wrong"); // RULE_03

  property p_rgmii_small;
    @(posedge hclk) disable iff (!hresetn) SMALL_PKG && $rose(strap_done_q) |-> rg_en_q;
  endproperty
  a_rgmii_small: assert property (p_rgmii_small) else $error("rgmii enable not one after reset"); // RULE_04

  property p_rsv_read;
    @(posedge hclk) disable iff (!hresetn)
      !hreadyout && is_reg(addr_q, pcr_pkg::IDX_RGMII_CTL) |=> hrdata[15:8] == 8'h00 && !hrdata[2];
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("reserved bits read nonzero"); // RULE_09

  property p_tm_const;
    @(posedge hclk) disable iff (!hresetn)
      !hreadyout && is_reg(addr_q, pcr_pkg::IDX_TEST_MIRROR) |=> (hrdata[15:0] & 16'hFE7E) == pcr_pkg::TM_RO_CONST;
  endproperty
  a_tm_const: assert property (p_tm_const) else $error("reserved defaults wrong"); // RULE_20

  property p_abort;
    @(posedge hclk) disable iff (!hresetn)
      rx_packet_active && pkt_over && !fe_q[pcr_pkg::FE_WDOFF_BIT] |=> rx_packet_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("long packet not aborted"); // RULE_11

  property p_no_abort;
    @(posedge hclk) disable iff (!hresetn) rx_packet_abort |-> $past(pkt_over) && $past(rx_packet_active);
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("abort without timeout"); // RULE_11

  property p_recov_start;
    @(posedge hclk) disable iff (!hresetn)
      unscramble_unlock && fe_q[pcr_pkg::FE_RECOV_LSB +: 4] != 4'h0 |=> unscramble_recovering;
  endproperty
  a_recov_start: assert property (p_recov_start) else $error("recovery not started"); // RULE_12

  property p_link_force;
    @(posedge hclk) disable iff (!hresetn) fe_q[pcr_pkg::FE_FORCE_BIT] |=> link_good_100;
  endproperty
  a_link_force: assert property (p_link_force) else $error("forced link not good"); // RULE_13

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn) hready && addr_take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong"); // one read wait state
endmodule : pcr_regs

/* File: bench/pcr_datapath_model.sv */
// Purpose: Receive datapath stand-in feeding the config bank's status inputs
// Assumes: Driven by task calls from the bench, changes right after hclk rises
// Notes:   Nibble and frame-end pulses ride on the active window
`timescale 1ns/1ps
module pcr_datapath_model (
  input  wire logic hclk,
  output logic      rx_packet_active,
  output logic      unscramble_unlock,
  output logic      link_qualified,
  output logic      rx_nibble_valid,
  output logic      rx_frame_end
);
  initial begin
    rx_packet_active  = 1'b0;
    unscramble_unlock = 1'b0;
    link_qualified    = 1'b0;
    rx_nibble_valid   = 1'b0;
    rx_frame_end      = 1'b0;
  end

  // ==========================================================
  // Frames
  // packet length and nibbles
  task automatic packet(input int cyc, input int nib);
    for (int i = 0; i < cyc; i++) begin
      @(posedge hclk);
      rx_packet_active <= 1'b1;
      rx_nibble_valid  <= (i < nib);
      rx_frame_end     <= (i == cyc - 1);
    end
    @(posedge hclk);
    rx_packet_active <= 1'b0;
    rx_nibble_valid  <= 1'b0;
    rx_frame_end     <= 1'b0;
  endtask : packet

  // ==========================================================
  // Lock and link events
  // unlock pulse
  task automatic unlock();
    @(posedge hclk);
    unscramble_unlock <= 1'b1;
    @(posedge hclk);
    unscramble_unlock <= 1'b0;
  endtask : unlock

  task automatic link(input logic v);
    @(posedge hclk);
    link_qualified <= v;
  endtask : link
endmodule : pcr_datapath_model

/* File: bench/tb_pcr_regs.sv */
// Purpose: Self-checking bench of the PHY configuration bank over AHB-Lite
// Assumes: Short timeout and millisecond counts set by parameter
// Notes:   Straps swept across four resets
`timescale 1ns/1ps
module tb_pcr_regs;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans, rx_ctrl_strap, rx_fifo_midlevel, tx_fifo_midlevel;
  logic [31:0] hwdata, hrdata, rd;
  logic        mirror_strap, rgmii_en_strap, rx_packet_active, unscramble_unlock;
  logic        link_qualified, rx_nibble_valid, rx_frame_end, internal_test_mode;
  logic        port_mirror, rgmii_enable, tx_clk_skew, rx_clk_skew, async_fifo_skip;
  logic        rx_packet_abort, unscramble_recovering, link_good_100, odd_nibble_seen;
  logic        improved_ternary_detect, improved_gap_detect, rx_block_decoder_skip;
  logic        scrambler_off, early_receive_valid;
  logic [14:0] outs;
  int          mismatches, num_checks, cyc, odd_cnt;
  logic [9:0]  idx [4] = '{pcr_pkg::IDX_TEST_MIRROR, pcr_pkg::IDX_RGMII_CTL,
                           pcr_pkg::IDX_RGMII_CTL2, pcr_pkg::IDX_FE_CFG};
  logic [15:0] rstv [4] = '{16'h0000, 16'h00D3, 16'h0000, 16'h07A0};
  logic [15:0] ones [4] = '{16'h1191, 16'h00FB, 16'h0010, 16'h0FFF};
  logic [15:0] zero [4] = '{16'h1010, 16'h0000, 16'h0000, 16'h0000};

  assign outs = {internal_test_mode, port_mirror, rgmii_enable, rx_fifo_midlevel, tx_fifo_midlevel,
                 tx_clk_skew, rx_clk_skew, async_fifo_skip, improved_ternary_detect,
                 improved_gap_detect, rx_block_decoder_skip, scrambler_off, early_receive_valid};

  pcr_regs #(.TIMEOUT_CYC(20), .MS_CYC(10)) i_pcr_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .rx_ctrl_strap(rx_ctrl_strap), .mirror_strap(mirror_strap),
    .rgmii_en_strap(rgmii_en_strap), .rx_packet_active(rx_packet_active),
    .unscramble_unlock(unscramble_unlock), .link_qualified(link_qualified),
    .rx_nibble_valid(rx_nibble_valid), .rx_frame_end(rx_frame_end),
    .internal_test_mode(internal_test_mode), .port_mirror(port_mirror),
    .rgmii_enable(rgmii_enable), .rx_fifo_midlevel(rx_fifo_midlevel),
    .tx_fifo_midlevel(tx_fifo_midlevel), .tx_clk_skew(tx_clk_skew), .rx_clk_skew(rx_clk_skew),
    .async_fifo_skip(async_fifo_skip), .rx_packet_abort(rx_packet_abort),
    .unscramble_recovering(unscramble_recovering), .link_good_100(link_good_100),
    .improved_ternary_detect(improved_ternary_detect), .improved_gap_detect(improved_gap_detect),
    .rx_block_decoder_skip(rx_block_decoder_skip), .scrambler_off(scrambler_off),
    .odd_nibble_seen(odd_nibble_seen), .early_receive_valid(early_receive_valid)
  );

  pcr_datapath_model i_pcr_datapath_model (
    .hclk(hclk), .rx_packet_active(rx_packet_active), .unscramble_unlock(unscramble_unlock),
    .link_qualified(link_qualified), .rx_nibble_valid(rx_nibble_valid), .rx_frame_end(rx_frame_end)
  );

  // ==========================================================
  // Clock, timeout, pulse counter
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (odd_nibble_seen === 1'b1) odd_cnt <= odd_cnt + 1;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'b00};
  endfunction : ba

  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= pcr_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(hresp, 1'b0);
  endtask : rchk

  task automatic wait_n(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : wait_n

  task automatic do_reset(input logic [1:0] s);
    @(posedge hclk);
    hresetn        <= 1'b0;
    rx_ctrl_strap  <= s;
    mirror_strap   <= s[0];
    rgmii_en_strap <= ~s[0];
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wait_n(2);
  endtask : do_reset

  // ==========================================================
  // Main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 12'h000; htrans = 2'h0; hwrite = 1'b0;
    hwdata = 32'h0; rx_ctrl_strap = 2'h0; mirror_strap = 1'b0; rgmii_en_strap = 1'b0;
    for (int i = 0; i < 4; i++) begin
      logic [1:0] s;
      logic       sel;
      s   = i[1:0] ^ 2'h2;
      sel = (s == pcr_pkg::STRAP_MODE1) || (s == pcr_pkg::STRAP_MODE2);
      do_reset(s);
      chk(outs, {sel, s[0], 13'h1AD0});
      rchk(ba(idx[0]), {16'h0, 16'h1010 | (16'(sel) << 7) | 16'(s[0])});
    end
    for (int i = 1; i < 4; i++) rchk(ba(idx[i]), {16'h0, rstv[i]});
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ba(idx[i]), 32'hFFFFFFFF);
      rchk(ba(idx[i]), {16'h0, ones[i]});
    end
    wait_n(2);
    chk(outs, 15'h7FFF);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ba(idx[i]), 32'h0);
      rchk(ba(idx[i]), {16'h0, zero[i]});
    end
    wait_n(2);
    chk(outs, 15'h0000);
    bus(1'b1, 12'h100, 32'hFFFFFFFF);
    rchk(12'h100, 32'h0);
    bus(1'b1, ba(pcr_pkg::IDX_FE_CFG), 32'h0042);
    wait_n(2);
    chk(link_good_100, 1'b1);
    i_pcr_datapath_model.packet(5, 3);
    i_pcr_datapath_model.packet(6, 4);
    wait_n(2);
    chk(odd_cnt, 1);
    bus(1'b1, ba(pcr_pkg::IDX_FE_CFG), 32'h0100);
    i_pcr_datapath_model.link(1'b1);
    wait_n(2);
    chk(link_good_100, 1'b1);
    i_pcr_datapath_model.link(1'b0);
    wait_n(2);
    chk(link_good_100, 1'b0);
    for (int k = 0; k < 2; k++) begin
      fork
        i_pcr_datapath_model.packet(30, 3);
        begin
          wait_n(28);
          chk(rx_packet_abort, k == 0);
        end
      join
      wait_n(2);
      chk(rx_packet_abort, 1'b0);
      chk(odd_cnt, 1);
      i_pcr_datapath_model.unlock();
      wait_n(5);
      chk(unscramble_recovering, k == 0);
      wait_n(40);
      chk(unscramble_recovering, 1'b0);
      bus(1'b1, ba(pcr_pkg::IDX_FE_CFG), 32'h0800);
    end
    report_and_stop();
  end
endmodule : tb_pcr_regs
